//--- sfsup_consts.vh
`ifndef SFSUP_CONSTS_VH
`define SFSUP_CONSTS_VH
// Register offsets
`define SFSUP_ADDR_STATUS   4'h0
`define SFSUP_ADDR_FAULT0   4'h1
`define SFSUP_ADDR_FAULT1   4'h2
`define SFSUP_ADDR_CTRL     4'h3
`define SFSUP_ADDR_IRQSTAT  4'h4
`define SFSUP_ADDR_IRQMASK  4'h5
`define SFSUP_ADDR_SUPPLY   4'h6
// Fault field positions, per channel
`define SFSUP_F_OT          0
`define SFSUP_F_OC          1
`define SFSUP_F_SC          2
`define SFSUP_F_OL          3
`define SFSUP_F_OS          4
`define SFSUP_F_LATCHW      5
// Common status bits
`define SFSUP_S_OV          0
`define SFSUP_S_UV          1
`define SFSUP_S_POR         6
`define SFSUP_STATW         8
// Control bits
`define SFSUP_C_CH0         0
`define SFSUP_C_CH1         1
`define SFSUP_C_FAILEN      2
`define SFSUP_C_DELATCH     3
`define SFSUP_CTRLW         4
`define SFSUP_CTRL_RST      4'h0
// Interrupt events
`define SFSUP_I_FAULT       0
`define SFSUP_I_FAILSAFE    1
`define SFSUP_I_POR         2
`define SFSUP_I_GNDLOSS     3
`define SFSUP_IRQW          4
// Fault shutdown time
`define SFSUP_CLK_MHZ       100
`define SFSUP_TFAULT_NS     20
`define SFSUP_TFAULT_CYC    ((`SFSUP_TFAULT_NS * `SFSUP_CLK_MHZ) / 1000)
// Idle levels of the synchronised monitors: supplies good, wake high
`define SFSUP_SYNC_IDLE     9'h128
`endif

//--- sfsup_supervisor.v
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "sfsup_consts.vh"
module sfsup_supervisor #(
    parameter CH = 2
) (
    input  wire           ref_clk,
    input  wire           resetn,
    input  wire [3:0]     regAddr,
    input  wire [7:0]     regWdata,
    input  wire           regWr,
    input  wire           regRd,
    output reg  [7:0]     regRdata,
    input  wire           vpwrUv,
    input  wire           vpwrExtLow,
    input  wire           vpwrOv,
    input  wire           vpwrPorOk,
    input  wire           vddFail,
    input  wire           vddPorOk,
    input  wire           devGndHigh,
    input  wire           sysGndLoss,
    input  wire           wake_reset_n,
    input  wire [CH-1:0]  directIn,
    input  wire [CH-1:0]  otDet,
    input  wire [CH-1:0]  ocDet,
    input  wire [CH-1:0]  scDet,
    input  wire [CH-1:0]  olDet,
    input  wire [CH-1:0]  osDet,
    output reg  [CH-1:0]  high_side_output,
    output reg            fault_status_n,
    output reg            failSafe,
    output reg            soEnable,
    output reg            current_sense_output,
    output reg            irq
);
    localparam NS = 9;
    localparam integer TFC_I = (`SFSUP_TFAULT_CYC < 1) ? 1 : `SFSUP_TFAULT_CYC;
    localparam [3:0] TFC = TFC_I[3:0];

    reg [NS-1:0] syncA_ff;
    reg [NS-1:0] syncB_ff;
    wire [NS-1:0] monRaw = {wake_reset_n, sysGndLoss, devGndHigh, vddPorOk, vddFail,
                            vpwrPorOk, vpwrOv, vpwrExtLow, vpwrUv};
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            // Idle levels avoid a false supply or wake edge after reset
            syncA_ff <= `SFSUP_SYNC_IDLE;
            syncB_ff <= `SFSUP_SYNC_IDLE;
        end else begin
            syncA_ff <= monRaw;
            syncB_ff <= syncA_ff;
        end
    end
    wire sUv   = syncB_ff[0];
    wire sExt  = syncB_ff[1];
    wire sOv   = syncB_ff[2];
    wire sPPor = syncB_ff[3];
    wire sVFl  = syncB_ff[4];
    wire sVPor = syncB_ff[5];
    wire sGndH = syncB_ff[6];
    wire sSysG = syncB_ff[7];
    wire sWake = syncB_ff[8];

    reg [`SFSUP_CTRLW-1:0]  ctrl_ff;
    reg [`SFSUP_STATW-1:0]  stat_ff;
    reg [`SFSUP_IRQW-1:0]   irqStat_ff;
    reg [`SFSUP_IRQW-1:0]   irqMask_ff;
    reg                     vddFailFs_ff;
    reg                     pPorPrev_ff;
    reg                     vPorPrev_ff;
    reg                     wakePrev_ff;
    reg                     vFlPrev_ff;
    reg [CH-1:0]            otPend_ff;
    reg [`SFSUP_F_LATCHW-1:0] flt_ff [0:CH-1];
    reg [3:0]               offCnt_ff [0:CH-1];

    wire rdStatus = regRd && (regAddr == `SFSUP_ADDR_STATUS);
    wire wrCtrl   = regWr && (regAddr == `SFSUP_ADDR_CTRL);
    wire fullPor  = !sPPor && !sVPor;
    wire clearAll = (sVFl && !sUv && !sExt) || fullPor;
    wire vddFs    = sVFl && ctrl_ff[`SFSUP_C_FAILEN];
    wire porRail  = sPPor && !pPorPrev_ff && !sVPor && !vPorPrev_ff;
    wire porLogic = sVPor && !vPorPrev_ff && !sPPor && !pPorPrev_ff;
    // wake transition power-on
    // Wake-up is leaving sleep: wake input or any direct input going high
    wire awake    = sWake || (|directIn);
    wire wakeEdge = awake && !wakePrev_ff;
    wire porWake  = wakeEdge && ((sPPor && pPorPrev_ff) || (sVPor && vPorPrev_ff));
    // rail recovery with logic supply up gives no reset
    wire porSet   = porRail || porLogic || porWake;
    wire fsNow    = vddFailFs_ff || sGndH;
    // system ground loss forces both channels off
    wire allOff   = sSysG;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pPorPrev_ff <= 1'b1;
            vPorPrev_ff <= 1'b1;
            wakePrev_ff <= 1'b1;
            vFlPrev_ff  <= 1'b0;
            vddFailFs_ff <= 1'b0;
        end else begin
            pPorPrev_ff <= sPPor;
            vPorPrev_ff <= sVPor;
            wakePrev_ff <= awake;
            vFlPrev_ff  <= sVFl;
            if (sVFl && !vFlPrev_ff)
                vddFailFs_ff <= ctrl_ff[`SFSUP_C_FAILEN];
            else if (!sVFl)
                vddFailFs_ff <= 1'b0;
        end
    end

    // Control register; resets it on logic supply fail when FAILEN is set
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff    <= `SFSUP_CTRL_RST;
            irqMask_ff <= {`SFSUP_IRQW{1'b0}};
        end else if ((sVFl && !vFlPrev_ff && ctrl_ff[`SFSUP_C_FAILEN]) || fullPor || porSet) begin
            ctrl_ff    <= `SFSUP_CTRL_RST;
            irqMask_ff <= {`SFSUP_IRQW{1'b0}};
        end else begin
            if (wrCtrl)
                ctrl_ff <= regWdata[`SFSUP_CTRLW-1:0];
            else
                ctrl_ff[`SFSUP_C_DELATCH] <= 1'b0;
            if (regWr && regAddr == `SFSUP_ADDR_IRQMASK)
                irqMask_ff <= regWdata[`SFSUP_IRQW-1:0];
        end
    end

    // Per-channel fault latches and output control
    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : chan
            wire [`SFSUP_F_LATCHW-1:0] det = {osDet[g], olDet[g], scDet[g], ocDet[g], otDet[g]};
            // load ground loss reported as open load via olDet
            wire latchEv = otDet[g] || ocDet[g] || scDet[g] || sUv;
            wire rdMe = regRd && (regAddr == ((g == 0) ? `SFSUP_ADDR_FAULT0 : `SFSUP_ADDR_FAULT1));
            wire delatch = wrCtrl && regWdata[`SFSUP_C_DELATCH];
            // below extended limit only overtemperature is recorded, later
            wire [`SFSUP_F_LATCHW-1:0] setV = sExt ? {`SFSUP_F_LATCHW{1'b0}} : det;
            reg  [`SFSUP_F_LATCHW-1:0] nxt_flt;
            reg                        latched_ff;
            reg                        nxt_hs;
            always @* begin
                nxt_flt = flt_ff[g];
                if (clearAll || (sVFl && ctrl_ff[`SFSUP_C_FAILEN]))
                    nxt_flt = {`SFSUP_F_LATCHW{1'b0}};
                // read clears when cause gone and delatched
                else if (rdMe && !latched_ff)
                    nxt_flt = flt_ff[g] & det;
                // Set wins over clear; otherwise unchanged
                nxt_flt = nxt_flt | setV;
                if (!sExt && otPend_ff[g])
                    nxt_flt[`SFSUP_F_OT] = 1'b1;
            end
            always @* begin
                // fail-safe follows direct input when rail normal
                if (fsNow)
                    nxt_hs = directIn[g] && !sUv && !sExt;
                else
                    nxt_hs = ctrl_ff[g];
                if (latchEv || latched_ff || allOff || (sOv && !fsNow))
                    nxt_hs = 1'b0;
            end
            always @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    flt_ff[g]    <= {`SFSUP_F_LATCHW{1'b0}};
                    latched_ff   <= 1'b0;
                    otPend_ff[g] <= 1'b0;
                    offCnt_ff[g] <= 4'h0;
                    high_side_output[g] <= 1'b0;
                end else begin
                    flt_ff[g] <= nxt_flt;
                    if (sExt && otDet[g])
                        otPend_ff[g] <= 1'b1;
                    else if (!sExt)
                        otPend_ff[g] <= 1'b0;
                    if (otDet[g] || ocDet[g] || scDet[g])
                        latched_ff <= 1'b1;
                    else if (delatch || clearAll)
                        latched_ff <= 1'b0;
                    if (latchEv)
                        offCnt_ff[g] <= TFC;
                    else if (offCnt_ff[g] != 4'h0)
                        offCnt_ff[g] <= offCnt_ff[g] - 4'h1;
                    high_side_output[g] <= nxt_hs && (offCnt_ff[g] == 4'h0);
                end
            end
        end
    endgenerate

    wire anyFault;
    wire [CH-1:0] chFault;
    genvar k;
    generate
        for (k = 0; k < CH; k = k + 1) begin : agg
            assign chFault[k] = otDet[k] | ocDet[k] | scDet[k] | olDet[k] | osDet[k];
        end
    endgenerate
    assign anyFault = |chFault;

    // Common status: overvoltage, undervoltage, power-on flag
    reg [`SFSUP_STATW-1:0] nxt_stat;
    always @* begin
        nxt_stat = stat_ff;
        if (clearAll)
            nxt_stat = {`SFSUP_STATW{1'b0}};
        else if (rdStatus)
            nxt_stat = stat_ff & {{(`SFSUP_STATW-2){1'b0}}, sUv, sOv};
        nxt_stat[`SFSUP_S_OV] = nxt_stat[`SFSUP_S_OV] | sOv;
        nxt_stat[`SFSUP_S_UV] = nxt_stat[`SFSUP_S_UV] | sUv;
        if (porSet)
            nxt_stat[`SFSUP_S_POR] = 1'b1;
    end

    wire [`SFSUP_IRQW-1:0] irqEv = {sGndH, porSet, fsNow && !failSafe, anyFault | sUv | sOv};
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stat_ff    <= {`SFSUP_STATW{1'b0}};
            irqStat_ff <= {`SFSUP_IRQW{1'b0}};
            fault_status_n <= 1'b1;
            failSafe   <= 1'b0;
            soEnable   <= 1'b0;
            current_sense_output <= 1'b0;
            irq        <= 1'b0;
            regRdata   <= 8'h00;
        end else begin
            stat_ff <= nxt_stat;
            // Event set wins over write-one clear
            if (regWr && regAddr == `SFSUP_ADDR_IRQSTAT)
                irqStat_ff <= (irqStat_ff & ~regWdata[`SFSUP_IRQW-1:0]) | irqEv;
            else
                irqStat_ff <= irqStat_ff | irqEv;
            irq <= |(irqStat_ff & irqMask_ff);
            // faults reach status pin without logic supply
            fault_status_n <= !(anyFault || sUv || sOv || fsNow);
            failSafe <= fsNow;
            // serial port stays up on rail excursions
            soEnable <= !sVFl && !sGndH;
            current_sense_output <= !sVFl && !fsNow && (|high_side_output);
            regRdata <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    `SFSUP_ADDR_STATUS:  regRdata <= stat_ff;
                    `SFSUP_ADDR_FAULT0:  regRdata <= {3'h0, flt_ff[0]};
                    `SFSUP_ADDR_FAULT1:  regRdata <= {3'h0, flt_ff[CH-1]};
                    `SFSUP_ADDR_CTRL:    regRdata <= {4'h0, ctrl_ff};
                    `SFSUP_ADDR_IRQSTAT: regRdata <= {4'h0, irqStat_ff};
                    `SFSUP_ADDR_IRQMASK: regRdata <= {4'h0, irqMask_ff};
                    `SFSUP_ADDR_SUPPLY:  regRdata <= {sWake, sSysG, sGndH, sVPor, sVFl, sPPor, sOv, sUv};
                    default:             regRdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // sfsup_supervisor

//--- sfsup_supervisor_assertions.sv
`timescale 1ns/1ps
module sfsup_chk #(
    parameter CH = 2
) (
    input wire          ref_clk,
    input wire          resetn,
    input wire          regRd,
    input wire [7:0]    regRdata,
    input wire          vpwrUv,
    input wire          vpwrExtLow,
    input wire          vpwrOv,
    input wire          vddFail,
    input wire          devGndHigh,
    input wire          sysGndLoss,
    input wire [CH-1:0] directIn,
    input wire [CH-1:0] otDet,
    input wire [CH-1:0] ocDet,
    input wire [CH-1:0] scDet,
    input wire [CH-1:0] olDet,
    input wire [CH-1:0] osDet,
    input wire [CH-1:0] high_side_output,
    input wire          fault_status_n,
    input wire          failSafe,
    input wire          soEnable,
    input wire          current_sense_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Fail-safe with a healthy rail and no shutdown fault
    wire quiet = failSafe & ~vpwrUv & ~vpwrOv & ~vpwrExtLow & ~sysGndLoss & ~|(otDet | ocDet | scDet);
    a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_fault_ch_off: assert property ((otDet[0] | ocDet[0] | scDet[0])[*5] |-> !high_side_output[0])
        else $error("channel 0 on during fault");
    a_uv_ch_off: assert property (vpwrUv[*5] |-> high_side_output == {CH{1'b0}})
        else $error("channel on during undervoltage");
    a_gnd_loss_off: assert property (sysGndLoss[*5] |-> high_side_output == {CH{1'b0}})
        else $error("channel on after system ground loss");
    a_gnd_high_fs: assert property (devGndHigh[*5] |-> failSafe)
        else $error("no fail-safe on device ground high");
    a_fs_direct_in: assert property ((quiet && $stable(directIn))[*6] |-> high_side_output == directIn)
        else $error("fail-safe channel not following direct input");
    a_diag_pin_low: assert property (((osDet | olDet) != {CH{1'b0}})[*4] |-> !fault_status_n)
        else $error("status pin high during diagnostic fault");
    a_no_so_vdd: assert property (vddFail[*4] |-> !soEnable)
        else $error("serial output enabled without logic supply");
    a_no_sense_vdd: assert property (vddFail[*4] |-> !current_sense_output)
        else $error("current sense active without logic supply");
    c_fail_safe: cover property ($rose(failSafe));
    c_fault_off: cover property ($fell(high_side_output[0]));
    c_pin_low: cover property ($fell(fault_status_n));
endmodule // sfsup_chk

//--- sfsup_host_model.sv
`timescale 1ns/1ps
module sfsup_host_model (
    input wire       ref_clk,
    output reg [3:0] regAddr,
    output reg [7:0] regWdata,
    output reg       regWr,
    output reg       regRd,
    output reg       wake_reset_n,
    input wire [7:0] regRdata
);
    initial begin
        {regAddr, regWdata, regWr, regRd} = 14'h0000;
        wake_reset_n = 1'b1;
    end
    task wr(input [3:0] a, input [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
endmodule // sfsup_host_model

//--- sfsup_supervisor_tb.sv
`timescale 1ns/1ps
`include "sfsup_consts.vh"
module sfsup_supervisor_tb;
    reg ref_clk = 0, resetn = 0, vpwrUv = 0, vpwrExtLow = 0, vpwrOv = 0, vpwrPorOk = 1;
    reg vddFail = 0, vddPorOk = 1, devGndHigh = 0, sysGndLoss = 0;
    reg [1:0] directIn = 0, otDet = 0, ocDet = 0, scDet = 0, olDet = 0, osDet = 0;
    wire [3:0] regAddr;
    wire [7:0] regWdata, regRdata;
    wire regWr, regRd, wake_reset_n, fault_status_n, failSafe, soEnable, current_sense_output, irq;
    wire [1:0] high_side_output;
    integer mismatches = 0, check_count = 0, seed = 84013, cyc = 0, i, c, k;
    reg [7:0] d;
    reg a;
    always #5 ref_clk = ~ref_clk;
    sfsup_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .wake_reset_n(wake_reset_n), .regRdata(regRdata));
    sfsup_supervisor #(.CH(2)) u_dut (.*);
    task summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task w;
        repeat (6) @(posedge ref_clk);
    endtask
    task rst;
        resetn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask
    // Drives fault kind k (0 OT, 1 OC, 2 SC) on channel c
    task setf(input integer k, input integer c, input v);
        case (k)
            0: otDet[c] <= v;
            1: ocDet[c] <= v;
            default: scDet[c] <= v;
        endcase
    endtask
    initial begin
        rst;
        chk("fsb_reset", 8'h01, {7'h00, fault_status_n});
        u_host.rd(4'hF, d); chk("unmapped", 8'h00, d);
        for (i = 0; i < 6; i = i + 1) begin
            c = $unsigned($random(seed)) % 2;
            k = $unsigned($random(seed)) % 3;
            u_host.wr(`SFSUP_ADDR_CTRL, 8'h03);
            setf(k, c, 1'b1); directIn <= $random(seed); w;
            chk("ch_off", 8'h00, {7'h00, high_side_output[c]});
            setf(k, c, 1'b0); u_host.wr(`SFSUP_ADDR_CTRL, 8'h0B); w;
            u_host.rd(`SFSUP_ADDR_FAULT0 + c, d); chk("flt_set", 8'h01, {7'h00, d[k]});
            u_host.rd(`SFSUP_ADDR_FAULT0 + c, d); chk("flt_clr", 8'h00, {7'h00, d[k]});
        end
        u_host.rd(`SFSUP_ADDR_IRQSTAT, d); chk("irq_fault", 8'h01, {7'h00, d[`SFSUP_I_FAULT]});
        u_host.wr(`SFSUP_ADDR_IRQMASK, 8'h0F); #1 a = irq;
        u_host.wr(`SFSUP_ADDR_IRQMASK, 8'h00); #1 chk("irq_mask", {7'h00, ~a}, {7'h00, irq});
        u_host.wr(`SFSUP_ADDR_IRQSTAT, 8'h0F);
        for (i = 0; i < 2; i = i + 1) begin
            u_host.wr(`SFSUP_ADDR_IRQMASK, i ? 8'h0F : 8'h00); #1 chk("irq_clr", 8'h00, {7'h00, irq});
        end
        u_host.wr(`SFSUP_ADDR_CTRL, 8'h03); vpwrOv <= 1'b1; w;
        u_host.rd(`SFSUP_ADDR_CTRL, d); chk("ctrl_ov", 8'h03, d);
        vpwrOv <= 1'b0;
        rst;
        otDet[0] <= 1'b1; w; otDet[0] <= 1'b0;
        u_host.wr(`SFSUP_ADDR_CTRL, 8'h04); vddFail <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            directIn <= $random(seed); w;
        end
        chk("fs_vdd", 8'h01, {7'h00, failSafe});
        chk("fs_follow", {6'h00, directIn}, {6'h00, high_side_output});
        vddFail <= 1'b0; w;
        u_host.rd(`SFSUP_ADDR_CTRL, d); chk("ctrl_rst", 8'h00, d);
        u_host.rd(`SFSUP_ADDR_FAULT0, d); chk("flt_vdd", 8'h00, d);
        rst; vddFail <= 1'b1; w;
        chk("fs_noen", 8'h00, {7'h00, failSafe});
        vddFail <= 1'b0; rst; devGndHigh <= 1'b1; w;
        chk("fs_gnd", 8'h01, {7'h00, failSafe});
        devGndHigh <= 1'b0; sysGndLoss <= 1'b1; w;
        chk("gnd_off", 8'h00, {6'h00, high_side_output});
        sysGndLoss <= 1'b0; olDet <= 2'h1; w;
        chk("ol_pin", 8'h00, {7'h00, fault_status_n});
        olDet <= 2'h0;
        rst; u_host.rd(`SFSUP_ADDR_STATUS, d);
        vpwrPorOk <= 1'b0; w; vpwrPorOk <= 1'b1; w;
        u_host.rd(`SFSUP_ADDR_STATUS, d); chk("por_none", 8'h00, {7'h00, d[`SFSUP_S_POR]});
        vddPorOk <= 1'b0; vpwrPorOk <= 1'b0; w; vpwrPorOk <= 1'b1; w;
        u_host.rd(`SFSUP_ADDR_STATUS, d); chk("por_rail", 8'h01, {7'h00, d[`SFSUP_S_POR]});
        vddPorOk <= 1'b1; directIn <= 2'h0; w; u_host.rd(`SFSUP_ADDR_STATUS, d);
        u_host.wake_reset_n <= 1'b0; w; u_host.wake_reset_n <= 1'b1; w;
        u_host.rd(`SFSUP_ADDR_STATUS, d); chk("por_wake", 8'h01, {7'h00, d[`SFSUP_S_POR]});
        summarize;
    end
endmodule // sfsup_supervisor_tb
bind sfsup_supervisor sfsup_chk #(.CH(CH)) u_chk (.*);
